// File: logic/ccp_channels.sv
/*
 * seven capture/compare/pwm channels (instances four to ten) with their
 * shared timer select registers, reached over apb.
 * assumes timer values and period pulses synchronous to REF_CLK and
 * pin inputs already synchronous to REF_CLK.
 */
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "ccp_defs.svh"

// Contract
// - one 16-bit data register per channel
// - mode 0000 disables and resets channel
// - mode 0010 toggles pin on match, sets flag
// - modes 0100-0111 capture fall, rise, 4th, 16th
// - mode 1000 starts low, match forces high
// - mode 1001 starts high, match forces low
// - mode 1010 match sets flag only
// - mode 1011 match sets flag, resets timer
// - 11xx is pwm, 10-bit duty from two fields
// - pwm: high byte buffers low byte duty
// - capture/compare: bytes hold value halves
// - instance seven select maps four timer pairs
// - instance six bit selects 1/2 or 5/2
// - instance five bit selects 1/2 or 5/4
// - instance four select 1/2,3/4,3/6; 11 reserved
// - instance ten bit selects 1/2 or 5/2
// - instance nine bit selects 1/2 or 5/4
// - instance eight select 1/2,3/4,3/6; 11 reserved
// - unimplemented bits ignore writes, read zero
// - control and data bytes all read/write
// - new capture overwrites; flag holds until cleared
module ccp_channels
(
    // clock and reset
    input  wire logic                  REF_CLK,
    input  wire logic                  RST_N,
    // apb slave
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [7:0]            PADDR,
    input  wire logic [31:0]           PWDATA,
    output logic      [31:0]           PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    // shared timers
    input  wire ccp_pkg::timers_t      TIMERS,
    output logic      [2:0]            TIMER_CLR,
    // channel pins and flags
    input  wire logic [6:0]            PIN_IN,
    output logic      [6:0]            PIN_OUT,
    output logic      [6:0]            PIN_OE_N,
    output logic      [6:0]            FLAGS
);
    import ccp_pkg::*;

    logic [7:0]  ctrl      [`CH_COUNT];
    logic [7:0]  data_low  [`CH_COUNT];
    logic [7:0]  data_high [`CH_COUNT];
    logic [1:0]  dc_buf    [`CH_COUNT];
    logic [3:0]  presc     [`CH_COUNT];
    mode_t       mode_prev [`CH_COUNT];
    logic [15:0] cc_val    [`CH_COUNT];
    logic [1:0]  cc_sel    [`CH_COUNT];
    logic [1:0]  pw_sel    [`CH_COUNT];
    mode_t       mode      [`CH_COUNT];
    logic [7:0]  tsel1;
    logic [7:0]  tsel2;
    logic [6:0]  pin_prev;
    logic [6:0]  match_prev;
    logic [6:0]  match;
    logic [6:0]  match_edge;
    logic [6:0]  entered;
    logic [6:0]  cap_event;
    logic [6:0]  flag_set;
    logic [6:0]  is_pwm;
    logic [6:0]  period_hit;
    logic [6:0]  pwm_on;
    logic [6:0]  drives;
    logic [2:0]  next_timer_clr;
    logic [7:0]  rd_byte;
    dec_t        dec;
    logic        wr;
    logic        setup;

    function automatic cc_timer_t cc_pick(input int k, input logic [7:0] s1,
                                          input logic [7:0] s2);
        logic [7:0] s;
        s = (k < 4) ? s1 : s2;
        case (k)
            0, 4:    // reserved 11 falls back to the 1/2 pair
                return (s[`SELP_HI:`SELP_LO] == 2'h1 || s[`SELP_HI:`SELP_LO] == 2'h2)
                       ? CC_T3 : CC_T1;
            1, 5:    return s[`SELQ_BIT] ? CC_T5 : CC_T1;
            2, 6:    return s[`SELR_BIT] ? CC_T5 : CC_T1;
            default: return (s[`SELS_HI:`SELS_LO] == 2'h0) ? CC_T1 : CC_T5;
        endcase
    endfunction : cc_pick

    function automatic pwm_timer_t pw_pick(input int k, input logic [7:0] s1,
                                           input logic [7:0] s2);
        logic [7:0] s;
        s = (k < 4) ? s1 : s2;
        case (k)
            0, 4:
                return (s[`SELP_HI:`SELP_LO] == 2'h1) ? PW_T4 :
                       (s[`SELP_HI:`SELP_LO] == 2'h2) ? PW_T6 : PW_T2;
            1, 5:    return s[`SELQ_BIT] ? PW_T4 : PW_T2;
            2, 6:    return PW_T2;
            default: return pwm_timer_t'(s[`SELS_HI:`SELS_LO]);
        endcase
    endfunction : pw_pick

    function automatic logic [7:0] t8_val(input logic [1:0] s, input timers_t t);
        case (s)
            PW_T2:   return t.t2;
            PW_T4:   return t.t4;
            PW_T6:   return t.t6;
            default: return t.t8;
        endcase
    endfunction : t8_val

    function automatic dec_t decode(input logic [7:0] a);
        dec_t d;
        d = '0;
        d.hit = 1'b1;
        d.ch = a[6:4];
        if (a == `OFF_TSEL1)
            d.kind = K_TSEL1;
        else if (a == `OFF_TSEL2)
            d.kind = K_TSEL2;
        else if (a == `OFF_FLAGS)
            d.kind = K_FLAGS;
        else if (a[7:4] <= `CH_LAST_NIB && a[3:0] == `OFF_CTRL)
            d.kind = K_CTRL;
        else if (a[7:4] <= `CH_LAST_NIB && a[3:0] == `OFF_LOW)
            d.kind = K_LOW;
        else if (a[7:4] <= `CH_LAST_NIB && a[3:0] == `OFF_HIGH)
            d.kind = K_HIGH;
        else
            d.hit = 1'b0;
        return d;
    endfunction : decode

    // zero wait states: read data is staged during the setup cycle
    assign dec = decode(PADDR);
    assign setup = PSEL && !PENABLE;
    assign wr = PSEL && PENABLE && PWRITE && dec.hit;
    assign PREADY = PSEL && PENABLE;

    always_comb
    begin
        next_timer_clr = 3'h0;
        for (int k = 0; k < `CH_COUNT; k++)
        begin
            mode[k] = mode_t'(ctrl[k][`MODE_HI:`MODE_LO]);
            cc_sel[k] = cc_pick(k, tsel1, tsel2);
            pw_sel[k] = pw_pick(k, tsel1, tsel2);
            case (cc_sel[k])
                CC_T1:   cc_val[k] = TIMERS.t1;
                CC_T3:   cc_val[k] = TIMERS.t3;
                default: cc_val[k] = TIMERS.t5;
            endcase
            entered[k] = mode[k] != mode_prev[k];
            match[k] = cc_val[k] == {data_high[k], data_low[k]};
            // a timer resting on the compare value fires once only
            match_edge[k] = match[k] && !match_prev[k];
            is_pwm[k] = mode[k][3] && mode[k][2];
            period_hit[k] = TIMERS.period[pw_sel[k]];
            // duty compare uses the 8-bit timer with zero fraction bits
            pwm_on[k] = {t8_val(pw_sel[k], TIMERS), 2'h0} < {data_high[k], dc_buf[k]};
            case (mode[k])
                MODE_CAP_FALL: cap_event[k] = pin_prev[k] && !PIN_IN[k];
                MODE_CAP_RISE: cap_event[k] = !pin_prev[k] && PIN_IN[k];
                MODE_CAP_4:    cap_event[k] = !pin_prev[k] && PIN_IN[k] &&
                                              presc[k] == `PRESC_4TH;
                MODE_CAP_16:   cap_event[k] = !pin_prev[k] && PIN_IN[k] &&
                                              presc[k] == `PRESC_16TH;
                default:       cap_event[k] = 1'b0;
            endcase
            case (mode[k])
                MODE_TOGGLE, MODE_SET_HIGH, MODE_SET_LOW, MODE_SOFT, MODE_SPECIAL:
                    flag_set[k] = match_edge[k];
                MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_4, MODE_CAP_16:
                    flag_set[k] = cap_event[k];
                default:
                    flag_set[k] = 1'b0;
            endcase
            drives[k] = is_pwm[k] || mode[k] == MODE_TOGGLE || mode[k] == MODE_SET_HIGH ||
                        mode[k] == MODE_SET_LOW;
            if (mode[k] == MODE_SPECIAL && match_edge[k])
                next_timer_clr[cc_sel[k]] = 1'b1;
        end
    end

    // configuration registers
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            tsel1 <= `TSEL_RST;
            tsel2 <= `TSEL_RST;
            for (int k = 0; k < `CH_COUNT; k++)
                ctrl[k] <= `CTRL_RST;
        end
        else if (wr)
        begin
            if (dec.kind == K_TSEL1)
                tsel1 <= PWDATA[7:0] & `TSEL1_MASK;
            if (dec.kind == K_TSEL2)
                tsel2 <= PWDATA[7:0] & `TSEL2_MASK;
            if (dec.kind == K_CTRL)
                ctrl[dec.ch] <= PWDATA[7:0] & `CTRL_MASK;
        end
    end

    // data register pair: capture wins over a software write in the same cycle
    always_ff @(posedge REF_CLK)
    begin
        for (int k = 0; k < `CH_COUNT; k++)
        begin
            if (!RST_N)
            begin
                data_low[k] <= `DATA_RST;
                data_high[k] <= `DATA_RST;
                dc_buf[k] <= 2'h0;
            end
            else if (cap_event[k])
            begin
                {data_high[k], data_low[k]} <= cc_val[k];
            end
            else
            begin
                if (wr && dec.kind == K_LOW && dec.ch == k[2:0])
                    data_low[k] <= PWDATA[7:0];
                if (is_pwm[k] && period_hit[k])
                begin
                    data_high[k] <= data_low[k];
                    dc_buf[k] <= ctrl[k][`DC_HI:`DC_LO];
                end
                else if (wr && dec.kind == K_HIGH && dec.ch == k[2:0])
                    data_high[k] <= PWDATA[7:0];
            end
        end
    end

    // edge history, prescaler and mode tracking
    always_ff @(posedge REF_CLK)
    begin
        for (int k = 0; k < `CH_COUNT; k++)
        begin
            if (!RST_N || mode[k] == MODE_OFF)
            begin
                presc[k] <= `PRESC_RST;
                match_prev[k] <= 1'b0;
                mode_prev[k] <= MODE_OFF;
                pin_prev[k] <= 1'b0;
            end
            else
            begin
                mode_prev[k] <= mode[k];
                match_prev[k] <= match[k];
                pin_prev[k] <= PIN_IN[k];
                if (entered[k] || cap_event[k])
                    presc[k] <= `PRESC_RST;
                else if (!pin_prev[k] && PIN_IN[k])
                    presc[k] <= presc[k] + `PRESC_STEP;
            end
        end
    end

    // pin level and drive
    always_ff @(posedge REF_CLK)
    begin
        for (int k = 0; k < `CH_COUNT; k++)
        begin
            if (!RST_N)
            begin
                PIN_OUT[k] <= 1'b0;
                PIN_OE_N[k] <= 1'b1;
            end
            else
            begin
                PIN_OE_N[k] <= !drives[k];
                case (mode[k])
                    MODE_TOGGLE:
                        if (match_edge[k])
                            PIN_OUT[k] <= !PIN_OUT[k];
                    MODE_SET_HIGH:
                        if (entered[k])
                            PIN_OUT[k] <= 1'b0;
                        else if (match_edge[k])
                            PIN_OUT[k] <= 1'b1;
                    MODE_SET_LOW:
                        if (entered[k])
                            PIN_OUT[k] <= 1'b1;
                        else if (match_edge[k])
                            PIN_OUT[k] <= 1'b0;
                    MODE_PWM0, MODE_PWM1, MODE_PWM2, MODE_PWM3:
                        PIN_OUT[k] <= pwm_on[k];
                    MODE_OFF, MODE_RSV1, MODE_RSV3:
                        PIN_OUT[k] <= 1'b0;
                    default:
                        PIN_OUT[k] <= PIN_OUT[k];
                endcase
            end
        end
    end

    // flags: write one to clear, a new event in the same cycle wins
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            FLAGS <= 7'h00;
        else if (wr && dec.kind == K_FLAGS)
            FLAGS <= (FLAGS & ~PWDATA[6:0]) | flag_set;
        else
            FLAGS <= FLAGS | flag_set;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            TIMER_CLR <= 3'h0;
        else
            TIMER_CLR <= next_timer_clr;
    end

    // read path
    always_comb
    begin
        case (dec.kind)
            K_CTRL:  rd_byte = ctrl[dec.ch];
            K_LOW:   rd_byte = data_low[dec.ch];
            K_HIGH:  rd_byte = data_high[dec.ch];
            K_TSEL1: rd_byte = tsel1;
            K_TSEL2: rd_byte = tsel2;
            default: rd_byte = {1'b0, FLAGS};
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else if (setup)
        begin
            PRDATA <= dec.hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            PSLVERR <= !dec.hit;
        end
    end

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    for (genvar g = 0; g < `CH_COUNT; g++)
    begin : chk
        off_pin_idle_a: assert property (mode[g] == MODE_OFF
            |=> PIN_OE_N[g] && !PIN_OUT[g]) else $error("disabled channel still drives");
        toggle_match_a: assert property (mode[g] == MODE_TOGGLE && match_edge[g]
            && !entered[g] |=> PIN_OUT[g] != $past(PIN_OUT[g]) && FLAGS[g])
            else $error("toggle on match missing");
        capture_load_a: assert property (cap_event[g] |=>
            {data_high[g], data_low[g]} == $past(cc_val[g]) && FLAGS[g])
            else $error("capture value not stored");
        set_high_a: assert property (mode[g] == MODE_SET_HIGH && entered[g]
            |=> !PIN_OUT[g])
            else $error("set high entry level wrong");
        set_low_a: assert property (mode[g] == MODE_SET_LOW && !entered[g] && match_edge[g]
            |=> !PIN_OUT[g])
            else $error("set low on match failed");
        soft_nodrive_a: assert property (mode[g] == MODE_SOFT |=> PIN_OE_N[g])
            else $error("software mode drives pin");
        pwm_reload_a: assert property (is_pwm[g] && period_hit[g] && !cap_event[g]
            |=> data_high[g] == $past(data_low[g]))
            else $error("duty buffer not reloaded");
        flag_hold_a: assert property (FLAGS[g] && !(wr && dec.kind == K_FLAGS)
            |=> FLAGS[g])
            else $error("flag dropped without clear");
        reserved_zero_a: assert property (ctrl[g][7:6] == 2'h0)
            else $error("unimplemented control bits set");
        capture_c: cover property (cap_event[g] ##1 FLAGS[g]);
        toggle_c: cover property (mode[g] == MODE_TOGGLE && match_edge[g]);
        pwm_c: cover property (is_pwm[g] && period_hit[g]);
    end

    special_clr_a: assert property (mode[0] == MODE_SPECIAL && match_edge[0]
        |=> TIMER_CLR[$past(cc_sel[0])])
        else $error("special trigger did not reset timer");

endmodule : ccp_channels

// File: logic/ccp_defs.svh
/*
 * named constants of the capture/compare/pwm channel bank: register
 * offsets, write masks, field positions, reset values and counts.
 * assumes byte addresses on an 8-bit apb address with 32-bit data.
 */
`ifndef CCP_DEFS_SVH
`define CCP_DEFS_SVH

`define CH_COUNT      7
`define CH_LAST_NIB   4'h6
`define OFF_CTRL      4'h0
`define OFF_LOW       4'h4
`define OFF_HIGH      4'h8
`define OFF_TSEL1     8'h80
`define OFF_TSEL2     8'h84
`define OFF_FLAGS     8'h88
`define CTRL_MASK     8'h3f
`define TSEL1_MASK    8'hd7
`define TSEL2_MASK    8'h17
`define MODE_HI       3
`define MODE_LO       0
`define DC_HI         5
`define DC_LO         4
`define SELP_HI       1
`define SELP_LO       0
`define SELQ_BIT      2
`define SELR_BIT      4
`define SELS_HI       7
`define SELS_LO       6
`define CTRL_RST      8'h00
`define TSEL_RST      8'h00
`define DATA_RST      8'h00
`define PRESC_RST     4'h0
`define PRESC_4TH     4'h3
`define PRESC_16TH    4'hf
`define PRESC_STEP    4'h1

`endif

// File: logic/ccp_pkg.sv
/*
 * types of the capture/compare/pwm channel bank.
 * assumes ccp_defs.svh for the numeric constants.
 */
package ccp_pkg;

    typedef enum logic [3:0] {
        MODE_OFF      = 4'b0000,
        MODE_RSV1     = 4'b0001,
        MODE_TOGGLE   = 4'b0010,
        MODE_RSV3     = 4'b0011,
        MODE_CAP_FALL = 4'b0100,
        MODE_CAP_RISE = 4'b0101,
        MODE_CAP_4    = 4'b0110,
        MODE_CAP_16   = 4'b0111,
        MODE_SET_HIGH = 4'b1000,
        MODE_SET_LOW  = 4'b1001,
        MODE_SOFT     = 4'b1010,
        MODE_SPECIAL  = 4'b1011,
        MODE_PWM0     = 4'b1100,
        MODE_PWM1     = 4'b1101,
        MODE_PWM2     = 4'b1110,
        MODE_PWM3     = 4'b1111
    } mode_t;

    typedef enum logic [1:0] {CC_T1 = 2'b00, CC_T3 = 2'b01, CC_T5 = 2'b10} cc_timer_t;
    typedef enum logic [1:0] {PW_T2 = 2'b00, PW_T4 = 2'b01, PW_T6 = 2'b10, PW_T8 = 2'b11}
        pwm_timer_t;

    typedef enum logic [2:0] {
        K_CTRL  = 3'b000,
        K_LOW   = 3'b001,
        K_HIGH  = 3'b010,
        K_TSEL1 = 3'b011,
        K_TSEL2 = 3'b100,
        K_FLAGS = 3'b101
    } reg_kind_t;

    typedef struct packed {
        logic      hit;
        reg_kind_t kind;
        logic [2:0] ch;
    } dec_t;

    // timer values as seen by the channels; period holds t2/t4/t6/t8 period pulses
    typedef struct packed {
        logic [15:0] t1;
        logic [15:0] t3;
        logic [15:0] t5;
        logic [7:0]  t2;
        logic [7:0]  t4;
        logic [7:0]  t6;
        logic [7:0]  t8;
        logic [3:0]  period;
    } timers_t;

endpackage : ccp_pkg

// File: verification/ccp_timer_model.sv
/* shared timer model: three 16-bit and four 8-bit timers with period pulses.
   assumes the bench gates counting with run and the block clears by clr. */
`timescale 1ns/10ps
module ccp_timer_model
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // control
    input  wire logic        run,
    input  wire logic [2:0]  clr,
    // timer values
    output ccp_pkg::timers_t timers
);
    import ccp_pkg::*;
    // distinct start values let the bench tell the capture timers apart
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            timers    <= '0;
            timers.t3 <= 16'h3000;
            timers.t5 <= 16'h5000;
        end
        else
        begin
            // counts on the block's own clock only, never asynchronously
            timers.t1     <= clr[0] ? 16'h0000 : timers.t1 + {15'h0000, run};
            timers.t3     <= clr[1] ? 16'h0000 : timers.t3 + {15'h0000, run};
            timers.t5     <= clr[2] ? 16'h0000 : timers.t5 + {15'h0000, run};
            timers.t2     <= timers.t2 + {7'h00, run};
            timers.t4     <= timers.t4 + {7'h00, run};
            timers.t6     <= timers.t6 + {7'h00, run};
            timers.t8     <= timers.t8 + {7'h00, run};
            timers.period <= {4{run}} & {timers.t8 == 8'hff, timers.t6 == 8'hff,
                                         timers.t4 == 8'hff, timers.t2 == 8'hff};
        end
    end
endmodule : ccp_timer_model

// File: verification/ccp_channels_bench.sv
/* self-checking bench of the channel bank: registers, compare modes,
   capture modes and timer selects. assumes ccp_timer_model as timers. */
`timescale 1ns/10ps
`include "ccp_defs.svh"
`define CHK(n, x, g) begin comparisons++; if ((g) !== (x)) begin fails++; \
    $display("mismatch %s expected %h seen %h", n, x, g); end end
module ccp_channels_bench;
    import ccp_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        run = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] q;
    logic        pready;
    logic        pslverr;
    logic        e;
    logic [6:0]  ext = 7'h00;
    logic [6:0]  pin_in;
    logic [6:0]  pout;
    logic [6:0]  oe_n;
    logic [6:0]  flags;
    logic [2:0]  clr;
    timers_t     timers;
    int          fails = 0;
    int          comparisons = 0;
    int          ticks = 0;
    // mode, flag, drive (0 drives, 1 released, 2 open), pin on entry, pin after
    localparam logic [8:0] cmp_tab [8] = '{9'b0010_1_00_0_1, 9'b1000_1_00_0_1,
        9'b1001_1_00_1_0, 9'b1010_1_01_0_0, 9'b1011_1_10_0_0, 9'b0000_0_01_0_0,
        9'b0001_0_01_0_0, 9'b0011_0_01_0_0};
    // channel, second register, select value, timer; select 11 of four and eight
    // is not in this table
    localparam logic [13:0] sel_tab [14] = '{{3'd0, 1'b0, 8'h00, 2'd0},
        {3'd0, 1'b0, 8'h01, 2'd1}, {3'd0, 1'b0, 8'h02, 2'd1}, {3'd1, 1'b0, 8'h04, 2'd2},
        {3'd2, 1'b0, 8'h10, 2'd2}, {3'd3, 1'b0, 8'h00, 2'd0}, {3'd3, 1'b0, 8'h40, 2'd2},
        {3'd3, 1'b0, 8'h80, 2'd2}, {3'd3, 1'b0, 8'hc0, 2'd2}, {3'd4, 1'b1, 8'h01, 2'd1},
        {3'd4, 1'b1, 8'h02, 2'd1}, {3'd5, 1'b1, 8'h04, 2'd2}, {3'd6, 1'b1, 8'h10, 2'd2},
        {3'd6, 1'b1, 8'h00, 2'd0}};

    always #50 clk = ~clk;
    // the wire follows the channel while it drives, else the outside
    assign pin_in = (~oe_n & pout) | (oe_n & ext);

    ccp_channels i_ccp_channels (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TIMERS(timers),
        .TIMER_CLR(clr), .PIN_IN(pin_in), .PIN_OUT(pout), .PIN_OE_N(oe_n),
        .FLAGS(flags));
    ccp_timer_model i_ccp_timer_model (.clk(clk), .rst_n(rst_n), .run(run),
        .clr(clr), .timers(timers));

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic expect_rd(input string n, input logic [7:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        `CHK(n, x, q[7:0])
    endtask : expect_rd

    task automatic expect_data(input logic [3:0] k, input logic [15:0] t);
        expect_rd("data low", {k, `OFF_LOW}, t[7:0]);
        expect_rd("data high", {k, `OFF_HIGH}, t[15:8]);
    endtask : expect_data

    // pin change, then time for sampling and the capture to land
    task automatic edge_to(input logic [6:0] v);
        @(posedge clk);
        ext <= v;
        repeat (3) @(posedge clk);
    endtask : edge_to

    task automatic regs_scenario;
        expect_rd("ctrl reset", 8'h00, 8'h00);
        expect_rd("tsel1 reset", `OFF_TSEL1, 8'h00);
        apb(1'b1, 8'h00, 8'hff);
        expect_rd("ctrl mask", 8'h00, 8'h3f);
        apb(1'b1, 8'h00, 8'h30);
        expect_rd("duty bits", 8'h00, 8'h30);
        apb(1'b1, `OFF_TSEL1, 8'hff);
        expect_rd("tsel1 mask", `OFF_TSEL1, 8'hd7);
        apb(1'b1, `OFF_TSEL2, 8'hff);
        expect_rd("tsel2 mask", `OFF_TSEL2, 8'h17);
        apb(1'b1, 8'h64, 8'ha5);
        apb(1'b1, 8'h68, 8'h5a);
        expect_data(4'h6, 16'h5aa5);
        apb(1'b0, 8'h90, 8'h00);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0, q)
        apb(1'b1, `OFF_TSEL1, 8'h00);
        apb(1'b1, `OFF_TSEL2, 8'h00);
    endtask : regs_scenario

    task automatic compare_scenario;
        logic [8:0]  c;
        logic [15:0] t;
        int          n;
        for (int i = 0; i < 8; i++)
        begin
            c = cmp_tab[i];
            apb(1'b1, 8'h00, 8'h00);
            apb(1'b1, `OFF_FLAGS, 8'h01);
            t = timers.t1 + 16'd60;
            apb(1'b1, 8'h04, t[7:0]);
            apb(1'b1, 8'h08, t[15:8]);
            apb(1'b1, 8'h00, {4'h0, c[8:5]});
            repeat (2) @(posedge clk);
            if (c[3:2] == 2'd0) `CHK("pin entry", c[1], pout[0])
            if (c[3:2] == 2'd1) `CHK("pin released", 1'b1, oe_n[0])
            n = 0;
            while (flags[0] !== 1'b1 && n < 100)
            begin
                @(posedge clk);
                n++;
            end
            repeat (3) @(posedge clk);
            `CHK("match flag", c[4], flags[0])
            if (c[3:2] == 2'd0) `CHK("pin match", c[0], pout[0])
            if (c[8:5] == 4'b1011) `CHK("timer reset", 1'b1, timers.t1 < 16'd8)
        end
    endtask : compare_scenario

    task automatic capture_scenario;
        logic [3:0] m;
        run <= 1'b0;
        apb(1'b1, 8'h00, 8'h04);
        apb(1'b1, `OFF_FLAGS, 8'h01);
        edge_to(7'h01);
        `CHK("rise in fall mode", 1'b0, flags[0])
        edge_to(7'h00);
        `CHK("fall capture", 1'b1, flags[0])
        expect_data(4'h0, timers.t1);
        apb(1'b1, 8'h00, 8'h05);
        edge_to(7'h01);
        run <= 1'b1;
        repeat (5) @(posedge clk);
        run <= 1'b0;
        edge_to(7'h00);
        edge_to(7'h01);
        expect_data(4'h0, timers.t1);
        `CHK("flag held", 1'b1, flags[0])
        for (int p = 0; p < 2; p++)
        begin
            m = (p == 0) ? 4'b0110 : 4'b0111;
            apb(1'b1, 8'h00, {4'h0, m});
            apb(1'b1, `OFF_FLAGS, 8'h01);
            edge_to(7'h00);
            for (int j = 0; j < ((p == 0) ? 4 : 16); j++)
            begin
                edge_to(7'h01);
                `CHK("prescaled capture", j == ((p == 0) ? 3 : 15), flags[0])
                edge_to(7'h00);
            end
        end
        apb(1'b1, 8'h00, 8'h00);
    endtask : capture_scenario

    task automatic select_scenario;
        logic [13:0] s;
        logic [15:0] t;
        logic [3:0]  k;
        for (int i = 0; i < 14; i++)
        begin
            s = sel_tab[i];
            k = {1'b0, s[13:11]};
            apb(1'b1, s[10] ? `OFF_TSEL2 : `OFF_TSEL1, s[9:2]);
            apb(1'b1, {k, `OFF_CTRL}, 8'h05);
            edge_to(7'h00);
            edge_to(7'h7f);
            t = (s[1:0] == 2'd0) ? timers.t1 : (s[1:0] == 2'd1) ? timers.t3 : timers.t5;
            expect_data(k, t);
            apb(1'b1, {1'b0, s[13:11], `OFF_CTRL}, 8'h00);
        end
    endtask : select_scenario

    // duty 0x80 with fraction 10: pin high while {t2, 00} is below {80, 10}
    task automatic pwm_scenario;
        logic [7:0] p2;
        run <= 1'b1;
        apb(1'b1, `OFF_TSEL1, 8'h00);
        apb(1'b1, 8'h04, 8'h80);
        apb(1'b1, 8'h00, 8'h2c);
        // more than one t2 period, so the buffer has reloaded at least once
        repeat (260) @(posedge clk);
        expect_rd("duty buffer", 8'h08, 8'h80);
        p2 = timers.t2;
        repeat (256)
        begin
            @(posedge clk);
            `CHK("pwm pin", {p2, 2'b00} < {8'h80, 2'b10}, pout[0])
            p2 = timers.t2;
        end
        `CHK("pwm drive", 1'b0, oe_n[0])
        apb(1'b1, 8'h00, 8'h00);
    endtask : pwm_scenario

    task close_out;
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    // a hang counts as a mismatch and still reaches the verdict
    always @(posedge clk)
    begin
        ticks++;
        if (ticks == 20000)
        begin
            fails++;
            close_out;
        end
    end

    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        regs_scenario;
        compare_scenario;
        capture_scenario;
        select_scenario;
        pwm_scenario;
        close_out;
    end
endmodule : ccp_channels_bench
